// ### cit_pkg.sv
// Contract
// - byte moves take one cycle, no flags
// - bit set/clear one cycle, others untouched
// - jump, call, returns take two cycles
// - skips test byte/bit, bump, optional copy
// - basic skip: one cycle, up to three
// - basic write to pc low: two cycles
// - watchdog refresh clears both status flags
// - power-down in one cycle, touches flags
// - table fetch: high to reg, low to memory
// - preincrement pointer before the table fetch
// - nibble exchange to memory or accumulator
// - extended words reach any sector directly
// - extended data ops take two cycles
// - add/sub flag sets; sub adds chained null
// - logic z only, rotate through carry c (plain rotates no flags), daa c
// - extended table fetch takes three cycles
// - extended skip: two cycles, up to four
// - extended write to pc low: three cycles
// - call pushes pc plus one, then jumps
`default_nettype none
package cit_pkg;
  // ==========================================================
  // sizes
  localparam int PC_W  = 13;
  localparam int DA_W  = 10;
  localparam int STK_N = 8;
  // ==========================================================
  // word classes, bits 15:14
  localparam logic [1:0] CLS_GEN = 2'h0;
  localparam logic [1:0] CLS_EXT = 2'h1;  // sector prefix
  localparam logic [1:0] CLS_BIT = 2'h2;
  localparam logic [1:0] CLS_BRA = 2'h3;  // dest=1 means call
  // general opcodes, bits 12:8
  localparam logic [4:0] OP_IDLE = 5'h00, OP_MOV  = 5'h01, OP_MOVI = 5'h02;
  localparam logic [4:0] OP_ADD  = 5'h03, OP_ADC  = 5'h04, OP_SUB  = 5'h05;
  localparam logic [4:0] OP_SBC  = 5'h06, OP_AND  = 5'h07, OP_OR   = 5'h08;
  localparam logic [4:0] OP_XOR  = 5'h09, OP_CPL  = 5'h0a, OP_INC  = 5'h0b;
  localparam logic [4:0] OP_DEC  = 5'h0c, OP_RR   = 5'h0d, OP_RRC  = 5'h0e;
  localparam logic [4:0] OP_RL   = 5'h0f, OP_RLC  = 5'h10, OP_SWAP = 5'h11;
  localparam logic [4:0] OP_DAA  = 5'h12, OP_CLR  = 5'h13, OP_SETB = 5'h14;
  localparam logic [4:0] OP_SZ   = 5'h15, OP_SNZ  = 5'h16, OP_SIZ  = 5'h17;
  localparam logic [4:0] OP_SDZ  = 5'h18, OP_TAB  = 5'h19, OP_TABL = 5'h1a;
  localparam logic [4:0] OP_RET  = 5'h1b, OP_RETA = 5'h1c, OP_INTERRUPT_EXIT = 5'h1d;
  localparam logic [4:0] OP_WDT  = 5'h1e, OP_HALT = 5'h1f;
  // bit kinds, bits 13:12 of a bit word
  localparam logic [1:0] BK_CLR = 2'h0, BK_SET = 2'h1;
  localparam logic [1:0] BK_SKZ = 2'h2, BK_SKNZ = 2'h3;
  // ==========================================================
  // core registers seen in data memory
  localparam logic [DA_W-1:0] A_PCL  = 10'h006;
  localparam logic [DA_W-1:0] A_TABLE_POINTER = 10'h007;
  localparam logic [DA_W-1:0] A_TABLE_HIGH_BYTE = 10'h008;
  localparam logic [DA_W-1:0] A_TBHP = 10'h009;
  localparam logic [4:0]      LAST_PAGE = 5'h1f;
  // ==========================================================
  // extra cycles after the first
  localparam logic [1:0] XC_BRANCH = 2'h1;
  localparam logic [1:0] XC_PCL    = 2'h1;
  // ==========================================================
  // register port
  localparam logic [2:0] R_ACC = 3'h0, R_STAT = 3'h1, R_PCL = 3'h2;
  localparam logic [2:0] R_PCH = 3'h3, R_CTRL = 3'h4, R_TABLE_POINTER = 3'h5;
  localparam logic [2:0] R_TABLE_HIGH_BYTE = 3'h6;
  localparam int         CTRL_RUN = 0;
  localparam logic       RUN_RST  = 1'b1;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [1:0] cls;
    logic       dest;   // 1: result to memory
    logic [4:0] op;
    logic [7:0] arg;
  } cit_word_t;
  typedef struct packed {
    logic to, sleep_entry_flag, cz, sc, ov, ac, c, z;
  } cit_flags_t;
  typedef struct packed {
    logic [7:0] res;
    cit_flags_t f;
  } cit_alu_t;
endpackage : cit_pkg
`default_nettype wire

// ### cit_core.sv
// Our own choices: strobed register access and the placing of the registers.
`default_nettype none
module cit_core (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 arst_n,
  // program memory, word valid for the address held
  output logic [cit_pkg::PC_W-1:0]  pm_addr,
  input  wire logic [15:0]          pm_rdata,
  // system
  input  wire logic                 wake_pin,
  input  wire logic                 dog_timeout,
  output logic                      dog_refresh,
  output logic                      power_down,
  // register port
  input  wire logic [2:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic [7:0]                reg_rdata
);
  import cit_pkg::*;

  // ==========================================================
  // state
  typedef enum logic [1:0] {ST_EXEC, ST_WAIT, ST_TABLE, ST_HALT} cit_state_t;

  cit_state_t             state, next_state;
  logic [PC_W-1:0]        pc, next_pc;          // program counter
  logic [7:0]             acc, next_acc;        // accumulator
  cit_flags_t             flags, next_flags;    // status flags
  logic [7:0]             table_pointer, next_table_pointer;      // table pointer
  logic [7:0]             table_high_byte, next_table_high_byte;      // table high byte
  logic [7:0]             tbhp, next_tbhp;      // table page
  logic [1:0]             sector, next_sector;  // prefix sector
  logic                   ext_on, next_ext;     // prefix seen
  logic                   skip_next, next_skip; // discard next word
  logic [1:0]             wait_cnt, next_wait;  // extra cycles left
  logic [DA_W-1:0]        tbl_dst, next_dst;    // table low byte dest
  logic [2:0]             sp;                   // stack pointer
  logic                   run;                  // core may execute
  logic                   wake_meta, wake_sync; // pin synchroniser
  logic                   next_refresh, next_pd;
  logic                   wr_en;                // data write
  logic [DA_W-1:0]        wr_addr;
  logic [7:0]             wr_val;
  logic                   push, pop;
  logic [PC_W-1:0]        stack [STK_N];
  logic [7:0]             dmem  [2**DA_W];

  // ==========================================================
  // helpers
  function automatic logic is_core_reg(input logic [DA_W-1:0] a);
    is_core_reg = (a == A_PCL) || (a == A_TABLE_POINTER) || (a == A_TABLE_HIGH_BYTE) || (a == A_TBHP);
  endfunction : is_core_reg

  function automatic logic [7:0] nib_swap(input logic [7:0] v);
    nib_swap = {v[3:0], v[7:4]};
  endfunction : nib_swap

  // arithmetic and logic with their flag effects
  function automatic cit_alu_t alu_op(input logic [4:0] op, input logic [7:0] a,
                                      input logic [7:0] m, input cit_flags_t f);
    cit_alu_t   o;
    logic [8:0] s;
    logic [4:0] h;
    logic       cin;
    logic       zuse;
    o.f  = f;
    o.res = m;
    s    = 9'h000;
    h    = 5'h00;
    cin  = 1'b0;
    zuse = 1'b0;
    case (op)
      OP_ADD, OP_ADC: begin
        cin      = (op == OP_ADC) & f.c;
        s        = {1'b0, a} + {1'b0, m} + {8'h00, cin};
        h        = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
        o.res    = s[7:0];
        o.f.c    = s[8];
        o.f.ac   = h[4];
        o.f.ov   = (a[7] == m[7]) && (s[7] != a[7]);
        o.f.sc   = o.f.ov ^ s[7];
        zuse     = 1'b1;
      end
      OP_SUB, OP_SBC: begin
        cin      = (op == OP_SBC) & ~f.c;
        s        = {1'b0, a} - {1'b0, m} - {8'h00, cin};
        h        = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, cin};
        o.res    = s[7:0];
        o.f.c    = ~s[8];   // carry means no borrow
        o.f.ac   = ~h[4];
        o.f.ov   = (a[7] != m[7]) && (s[7] != a[7]);
        o.f.sc   = o.f.ov ^ s[7];
        // chained null keeps a multi-byte zero test alive
        o.f.cz   = (s[7:0] == 8'h00) & ((op == OP_SUB) | f.cz);
        zuse     = 1'b1;
      end
      OP_AND: begin o.res = a & m; zuse = 1'b1; end
      OP_OR:  begin o.res = a | m; zuse = 1'b1; end
      OP_XOR: begin o.res = a ^ m; zuse = 1'b1; end
      OP_CPL: begin o.res = ~m;    zuse = 1'b1; end
      OP_INC: begin o.res = m + 8'h01; zuse = 1'b1; end
      OP_DEC: begin o.res = m - 8'h01; zuse = 1'b1; end
      OP_RR:  o.res = {m[0], m[7:1]};
      OP_RL:  o.res = {m[6:0], m[7]};
      OP_RRC: begin o.res = {f.c, m[7:1]}; o.f.c = m[0]; end
      OP_RLC: begin o.res = {m[6:0], f.c}; o.f.c = m[7]; end
      OP_SWAP: o.res = nib_swap(m);
      OP_DAA: begin
        s = {1'b0, a};
        if (a[3:0] > 4'h9 || f.ac) s = s + 9'h006;
        if (s[7:4] > 4'h9 || f.c || s[8]) s = s + 9'h060;
        o.res = s[7:0];
        o.f.c = s[8] | f.c;
      end
      OP_CLR:  o.res = 8'h00;
      OP_SETB: o.res = 8'hff;
      default: o.res = m;
    endcase
    if (zuse) o.f.z = (o.res == 8'h00);
    alu_op = o;
  endfunction : alu_op

  // ==========================================================
  // decode of the word at pc
  cit_word_t        w;
  logic [DA_W-1:0]  ea;        // effective data address
  logic [7:0]       rd_val;    // operand byte
  logic [7:0]       dm_q;
  cit_alu_t         alu;
  logic [7:0]       bit_mask;
  logic             bit_val;
  logic [7:0]       bump;      // skip increment or decrement
  logic [PC_W-1:0]  pc_inc;
  logic [7:0]       tbl_ptr;
  logic [PC_W-1:0]  tbl_addr;
  logic             alu_to_mem;

  assign w        = cit_word_t'(pm_rdata);
  // sector prefix opens all four sectors, else sector 0
  assign ea       = ext_on ? {sector, w.arg} : {2'b00, w.arg};
  assign dm_q     = dmem[ea];
  assign rd_val   = (ea == A_PCL)  ? pc[7:0] :
                    (ea == A_TABLE_POINTER) ? table_pointer :
                    (ea == A_TABLE_HIGH_BYTE) ? table_high_byte :
                    (ea == A_TBHP) ? tbhp : dm_q;
  assign alu      = alu_op(w.op, acc, rd_val, flags);
  assign bit_mask = 8'h01 << w.op[2:0];
  assign bit_val  = |(rd_val & bit_mask);
  assign bump     = (w.op == OP_SIZ) ? rd_val + 8'h01 : rd_val - 8'h01;
  assign pc_inc   = pc + 13'h0001;
  // with dest set, the pointer moves before the fetch
  assign tbl_ptr  = w.dest ? table_pointer + 8'h01 : table_pointer;
  assign tbl_addr = {(w.op == OP_TABL) ? LAST_PAGE : tbhp[4:0], tbl_ptr};
  assign alu_to_mem = w.dest || (w.op == OP_DAA) || (w.op == OP_CLR) ||
                      (w.op == OP_SETB);

  // ==========================================================
  // execute: one pass per clock, one clock per cycle
  always_comb begin
    next_state   = state;
    next_wait    = wait_cnt;
    next_pc      = pc;
    next_acc     = acc;
    next_flags   = flags;
    next_table_pointer    = table_pointer;
    next_table_high_byte    = table_high_byte;
    next_tbhp    = tbhp;
    next_sector  = sector;
    next_ext     = ext_on;
    next_skip    = skip_next;
    next_dst     = tbl_dst;
    next_refresh = 1'b0;
    next_pd      = power_down;
    wr_en        = 1'b0;
    wr_addr      = ea;
    wr_val       = 8'h00;
    push         = 1'b0;
    pop          = 1'b0;
    case (state)
      ST_EXEC: begin
        if (run) begin
          next_pc  = pc_inc;
          next_ext = 1'b0;
          if (skip_next) begin
            // a skipped prefix drags its word along, costing one more
            next_skip = (w.cls == CLS_EXT);
          end else begin
            case (w.cls)
              CLS_EXT: begin
                next_ext    = 1'b1;
                next_sector = w.arg[1:0];
              end
              CLS_BRA: begin
                next_pc    = {w.op, w.arg};
                push       = w.dest;
                next_state = ST_WAIT;
                next_wait  = XC_BRANCH;
              end
              CLS_BIT: begin
                case ({w.dest, w.op[4]})
                  BK_CLR: begin
                    wr_en  = 1'b1;
                    wr_val = rd_val & ~bit_mask;
                  end
                  BK_SET: begin
                    wr_en  = 1'b1;
                    wr_val = rd_val | bit_mask;
                  end
                  BK_SKZ:  next_skip = ~bit_val;
                  default: next_skip = bit_val;
                endcase
              end
              default: begin
                case (w.op)
                  OP_IDLE: ;
                  OP_MOV: begin
                    if (w.dest) begin
                      wr_en  = 1'b1;
                      wr_val = acc;
                    end else begin
                      next_acc = rd_val;
                    end
                  end
                  OP_MOVI: next_acc = w.arg;
                  OP_SZ: begin
                    next_skip = (rd_val == 8'h00);
                    if (w.dest) next_acc = rd_val;
                  end
                  OP_SNZ: next_skip = (rd_val != 8'h00);
                  OP_SIZ, OP_SDZ: begin
                    next_skip = (bump == 8'h00);
                    if (w.dest) begin
                      wr_en  = 1'b1;
                      wr_val = bump;
                    end else begin
                      next_acc = bump;
                    end
                  end
                  OP_TAB, OP_TABL: begin
                    next_table_pointer  = tbl_ptr;
                    next_dst   = ea;
                    next_state = ST_TABLE;
                  end
                  OP_RET, OP_RETA, OP_INTERRUPT_EXIT: begin
                    pop        = 1'b1;
                    next_pc    = stack[sp - 3'h1];
                    next_state = ST_WAIT;
                    next_wait  = XC_BRANCH;
                    if (w.op == OP_RETA) next_acc = w.arg;
                  end
                  OP_WDT: begin
                    next_refresh   = 1'b1;
                    next_flags.to  = 1'b0;
                    next_flags.sleep_entry_flag = 1'b0;
                  end
                  OP_HALT: begin
                    next_flags.to  = 1'b0;
                    next_flags.sleep_entry_flag = 1'b1;
                    next_pd        = 1'b1;
                    next_state     = ST_HALT;
                  end
                  default: begin
                    next_flags = alu.f;
                    if (alu_to_mem) begin
                      wr_en  = 1'b1;
                      wr_val = alu.res;
                    end else begin
                      next_acc = alu.res;
                    end
                  end
                endcase
              end
            endcase
          end
        end
      end
      ST_WAIT: begin
        next_wait = wait_cnt - 2'h1;
        if (wait_cnt == 2'h1) next_state = ST_EXEC;
      end
      ST_TABLE: begin
        // program memory now shows the table word
        next_table_high_byte  = pm_rdata[15:8];
        wr_en      = 1'b1;
        wr_addr    = tbl_dst;
        wr_val     = pm_rdata[7:0];
        next_state = ST_EXEC;
      end
      ST_HALT: begin
        if (wake_sync || dog_timeout) begin
          next_pd    = 1'b0;
          next_state = ST_EXEC;
        end
      end
      default: next_state = ST_EXEC;
    endcase
    // core registers written through the data path
    if (wr_en) begin
      if (wr_addr == A_TABLE_POINTER) next_table_pointer = wr_val;
      if (wr_addr == A_TABLE_HIGH_BYTE) next_table_high_byte = wr_val;
      if (wr_addr == A_TBHP) next_tbhp = wr_val;
      // a jump through pc low costs one more cycle
      if (wr_addr == A_PCL && state == ST_EXEC) begin
        next_pc    = {pc[PC_W-1:8], wr_val};
        next_state = ST_WAIT;
        next_wait  = XC_PCL;
      end
    end
    // a timeout in the refresh cycle still lands
    next_flags.to = next_flags.to | dog_timeout;
  end

  // ==========================================================
  // core registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_EXEC;
      wait_cnt  <= 2'h0;
      pc        <= '0;
      pm_addr   <= '0;
      acc       <= 8'h00;
      flags     <= '0;
      table_pointer      <= 8'h00;
      table_high_byte      <= 8'h00;
      tbhp      <= 8'h00;
      sector    <= 2'h0;
      ext_on    <= 1'b0;
      skip_next <= 1'b0;
      tbl_dst   <= '0;
      sp        <= 3'h0;
      dog_refresh <= 1'b0;
      power_down  <= 1'b0;
    end else begin
      state     <= next_state;
      wait_cnt  <= next_wait;
      pc        <= next_pc;
      // the table cycle points memory away from pc
      pm_addr   <= (next_state == ST_TABLE) ? tbl_addr : next_pc;
      acc       <= next_acc;
      flags     <= next_flags;
      table_pointer      <= next_table_pointer;
      table_high_byte      <= next_table_high_byte;
      tbhp      <= next_tbhp;
      sector    <= next_sector;
      ext_on    <= next_ext;
      skip_next <= next_skip;
      tbl_dst   <= next_dst;
      sp        <= sp + {2'b00, push} - {2'b00, pop};
      dog_refresh <= next_refresh;
      power_down  <= next_pd;
    end
  end

  // ==========================================================
  // stack and data memory, no reset on storage
  always_ff @(posedge clk) begin
    if (push) stack[sp] <= pc_inc;
    if (wr_en && !is_core_reg(wr_addr)) dmem[wr_addr] <= wr_val;
  end

  // ==========================================================
  // wake pin synchroniser
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
    end
  end

  // ==========================================================
  // register port, read data only in the following cycle
  logic [7:0] reg_mux;
  assign reg_mux = (reg_addr == R_ACC)  ? acc :
                   (reg_addr == R_STAT) ? flags :
                   (reg_addr == R_PCL)  ? pc[7:0] :
                   (reg_addr == R_PCH)  ? {3'b000, pc[PC_W-1:8]} :
                   (reg_addr == R_CTRL) ? {6'h00, power_down, run} :
                   (reg_addr == R_TABLE_POINTER) ? table_pointer :
                   (reg_addr == R_TABLE_HIGH_BYTE) ? table_high_byte : 8'h00;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run       <= RUN_RST;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == R_CTRL) run <= reg_wdata[CTRL_RUN];
      reg_rdata <= reg_rd ? reg_mux : 8'h00;
    end
  end
endmodule : cit_core
`default_nettype wire

// ### cit_pmem_model.sv
`default_nettype none
// ==========================================
// program memory seen by the core
module cit_pmem_model (
  // fetch port
  input  wire logic [cit_pkg::PC_W-1:0] pm_addr,
  output logic [15:0]                   pm_rdata
);
  import cit_pkg::*;
  // full range, loaded by the bench while the core is held in reset
  logic [15:0] mem [0:(1<<PC_W)-1];
  // same-cycle answer, the core decodes the word at the address it holds
  assign pm_rdata = mem[pm_addr];
endmodule : cit_pmem_model
`default_nettype wire

// ### cit_core_properties.sv
`default_nettype none
// ==========================================
// timing checks at the core pins
module cit_core_properties (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      arst_n,
  // program memory
  input wire logic [cit_pkg::PC_W-1:0]  pm_addr,
  input wire logic [15:0]               pm_rdata,
  // system
  input wire logic                      wake_pin,
  input wire logic                      dog_timeout,
  input wire logic                      dog_refresh,
  input wire logic                      power_down,
  // register port
  input wire logic [2:0]                reg_addr,
  input wire logic [7:0]                reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [7:0]                reg_rdata
);
  import cit_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // helpers
  logic [PC_W-1:0] q_addr;  // address one cycle back
  cit_word_t       qw;      // word one cycle back
  cit_word_t       w;       // word now
  assign w = pm_rdata;
  // remember the last word, to tell an executed word from a wait slot
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q_addr <= '0;
      qw     <= '0;
    end else begin
      q_addr <= pm_addr;
      qw     <= pm_rdata;
    end
  end
  // one-cycle word before: skips and branches excluded, they may hide a wait
  wire logic q_plain = (qw.cls == CLS_GEN && qw.op < OP_SZ) || (qw.cls == CLS_BIT && !qw.dest);
  // word at pm_addr runs at the next edge
  wire logic fresh   = q_plain && pm_addr == q_addr + 13'h0001 && !power_down;
  wire logic no_pcl  = w.arg != A_PCL[7:0];
  wire logic mv1     = w.cls == CLS_GEN && (w.op == OP_MOV || w.op == OP_MOVI
                       || w.op == OP_SWAP) && no_pcl;
  wire logic pclw    = w.cls == CLS_GEN && w.op == OP_MOV && w.dest && !no_pcl;
  wire logic is_ret  = w.cls == CLS_GEN && (w.op == OP_RET || w.op == OP_RETA
                       || w.op == OP_INTERRUPT_EXIT);
  // ==========================================
  // assertions
  a_move_one_cycle: assert property (fresh && mv1
    |=> pm_addr == $past(pm_addr) + 13'h0001) else $error("move or swap not one cycle");
  a_bit_one_cycle: assert property (fresh && w.cls == CLS_BIT && !w.dest && no_pcl
    |=> pm_addr == $past(pm_addr) + 13'h0001) else $error("bit op took more than one cycle");
  a_branch_two_cycle: assert property (fresh && w.cls == CLS_BRA
    |=> pm_addr == $past(pm_rdata[12:0]) ##1 $stable(pm_addr)) else $error("branch timing");
  a_call_then_return: assert property (fresh && w.cls == CLS_BRA && w.dest ##2 is_ret
    |=> pm_addr == $past(pm_addr, 3) + 13'h0001) else $error("return address wrong");
  a_table_last_page: assert property (fresh && w.cls == CLS_GEN && w.op == OP_TABL
    |=> pm_addr[12:8] == LAST_PAGE ##1 pm_addr == $past(pm_addr, 2) + 13'h0001)
    else $error("table fetch address or return wrong");
  a_refresh_one_cycle: assert property (fresh && w.cls == CLS_GEN && w.op == OP_WDT
    |=> dog_refresh && pm_addr == $past(pm_addr) + 13'h0001) else $error("refresh timing");
  a_refresh_cause: assert property (dog_refresh |-> $past(pm_rdata[15:14]) == CLS_GEN
    && $past(pm_rdata[12:8]) == OP_WDT) else $error("refresh without refresh word");
  a_halt_enters_sleep: assert property (fresh && w.cls == CLS_GEN && w.op == OP_HALT
    |=> power_down) else $error("power-down not entered in one cycle");
  a_pcl_two_cycle: assert property (fresh && pclw
    |=> pm_addr[12:8] == $past(pm_addr[12:8]) ##1 $stable(pm_addr)) else $error("pc low write");
  // main scenarios reached
  c_call: cover property (fresh && w.cls == CLS_BRA && w.dest);
  c_sleep: cover property ($rose(power_down));
  c_refresh: cover property (dog_refresh);
endmodule : cit_core_properties
bind cit_core cit_core_properties cit_core_properties_i (
  .clk(clk), .arst_n(arst_n), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .wake_pin(wake_pin),
  .dog_timeout(dog_timeout), .dog_refresh(dog_refresh), .power_down(power_down),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata));
`default_nettype wire

// ### cit_core_tb_top.sv
`default_nettype none
module cit_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cit_pkg::*;
  // ==========================================
  // signals
  logic            clk = 1'b0;
  logic            arst_n = 1'b0;
  logic [PC_W-1:0] pm_addr;
  logic [15:0]     pm_rdata;
  logic            wake_pin = 1'b0;
  logic            dog_timeout = 1'b0;
  logic            dog_refresh;
  logic            power_down;
  logic [2:0]      reg_addr = 3'h0;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [7:0]      reg_rdata;
  int              n_errors = 0;
  int              checks_done = 0;
  int              seed = 40;
  // 125 MHz
  always #4 clk = ~clk;
  // ==========================================
  // design and program memory
  cit_core cit_core_i (.clk(clk), .arst_n(arst_n), .pm_addr(pm_addr), .pm_rdata(pm_rdata),
    .wake_pin(wake_pin), .dog_timeout(dog_timeout), .dog_refresh(dog_refresh),
    .power_down(power_down), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  cit_pmem_model cit_pmem_model_i (.pm_addr(pm_addr), .pm_rdata(pm_rdata));
  // ==========================================
  // compare a pin or fetch address
  task automatic chk(input string s, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", s, exp, got);
    end
  endtask : chk
  // one register cycle; read data taken in the cycle after the strobe
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] v,
                     output logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : bus
  // read a register and compare the masked value
  task automatic chk_reg(input string s, input logic [2:0] a, input logic [7:0] mask,
                         input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, a, 8'h00, d);
    checks_done++;
    if ((d & mask) !== exp) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", s, exp, d & mask);
    end
  endtask : chk_reg
  // blank memory under reset, so a stray fetch sees idle words
  task automatic clear;
    arst_n <= 1'b0;
    for (int i = 0; i < (1 << PC_W); i++) cit_pmem_model_i.mem[i] = 16'h0000;
  endtask : clear
  task automatic load(input int base, input logic [15:0] w[$]);
    foreach (w[i]) cit_pmem_model_i.mem[base + i] = w[i];
  endtask : load
  // release reset and follow the expected fetch address cycle by cycle
  task automatic go(input int tr[$]);
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    foreach (tr[i]) begin
      @(posedge clk);
      #1 chk("pm_addr", 16'(tr[i]), 16'(pm_addr));
    end
  endtask : go
  task automatic results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  // ==========================================
  // scenarios
  initial begin
    logic [7:0]  imm;
    logic [7:0]  m;
    logic [15:0] tw;
    logic [7:0]  d;
    int          n;
    // moves, bits, call/return, skips, preinc table fetch, pc low write
    imm = 8'($random(seed)) | 8'h02;  // bit 1 kept high so the bit-5 test never skips
    tw = 16'($random(seed));
    m = imm | 8'h01;
    m[6] = 1'b0;
    m = {m[3:0], m[7:4]};
    clear();
    load(0, {16'h0200 | imm, 16'h2120, 16'h9020, 16'h8620, 16'h3120, 16'hE040, 16'h1120,
      16'hA520, 16'hB420, 16'h02FF, 16'h0203, 16'h2107, 16'h3A22, 16'h0230, 16'h2106});
    load(64, {16'h1C33});
    load(48, {16'h0120, 16'h0922, 16'hC032});
    load(7940, {tw});
    go({1, 2, 3, 4, 5, 64, 64, 6, 6, 7, 8, 9, 10, 11, 12, 7940, 13, 14, 48, 48, 49, 50, 50,
      50});
    chk_reg("acc", R_ACC, 8'hFF, m ^ tw[7:0]);
    chk_reg("table_high_byte", R_TABLE_HIGH_BYTE, 8'hFF, tw[15:8]);
    chk_reg("table_pointer", R_TABLE_POINTER, 8'hFF, 8'h04);
    @(posedge clk);
    dog_timeout <= 1'b1;
    @(posedge clk);
    dog_timeout <= 1'b0;
    // timeout sets expiry; the xor above may only have moved zero
    chk_reg("status", R_STAT, 8'hFF, {7'h40, (m ^ tw[7:0]) == 8'h00});
    bus(1'b1, R_CTRL, 8'h00, d);
    chk_reg("run", R_CTRL, 8'h01, 8'h00);
    bus(1'b1, R_CTRL, 8'h01, d);
    chk_reg("unmapped", 3'h7, 8'hFF, 8'h00);
    // extended sector access, bump skips over a prefixed word, refresh, pc low, sleep
    clear();
    load(0, {16'h02FF, 16'h4002, 16'h2110, 16'h4002, 16'h3710, 16'h4002, 16'h0277, 16'h4002,
      16'h3510, 16'h0277, 16'h1E00, 16'h0220, 16'h4000, 16'h2106});
    // at 32: prefixed copy-skip, prefixed table fetch from word 0, prefixed subtract
    load(32, {16'h0000, 16'h4002, 16'h3510, 16'h0277, 16'h4000, 16'h1922, 16'h4002, 16'h0510,
      16'h1F00});
    go({1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 32, 32, 33, 34, 35, 36, 37, 0, 38, 39, 40,
      41});
    @(posedge clk);
    #1 chk("power_down", 16'h0001, {15'h0000, power_down});
    chk_reg("acc", R_ACC, 8'hFF, 8'h00);
    chk_reg("status", R_STAT, 8'hE1, 8'h61);
    chk_reg("table_high_byte", R_TABLE_HIGH_BYTE, 8'hFF, 8'h02);
    @(posedge clk);
    wake_pin <= 1'b1;
    n = 0;
    while (power_down !== 1'b0 && n < 10) begin
      @(posedge clk);
      #1 n++;
    end
    chk("wake", 16'h0000, {15'h0000, power_down});
    wake_pin <= 1'b0;
    results();
  end
  // both programs need well under 400 cycles; 5000 leaves room for slow wake-up
  initial begin
    #40000;
    n_errors++;
    results();
  end
endmodule : cit_core_tb_top
`default_nettype wire
